/* File: inc/eewr_pkg.sv */
// Shared constants and types for the serial EEPROM target logic
package eewr_pkg;

   // ----------------------------------------------------------------
   // Array geometry
   // ----------------------------------------------------------------
   localparam int unsigned BASE_DEPTH   = 256;  // 2K bits, smallest size
   localparam int unsigned ADDR_W       = 11;   // Widest word address (16K)
   localparam int unsigned PAGE_SMALL   = 8;    // Page bytes, 2K size
   localparam int unsigned PAGE_LARGE   = 16;   // Page bytes, larger sizes
   localparam int unsigned PAGE_MAX     = 16;

   // ----------------------------------------------------------------
   // Serial framing
   // ----------------------------------------------------------------
   localparam logic [3:0]  ACK_BIT      = 4'h8; // Rising edges before ack clock
   localparam logic [2:0]  SEL_ALL      = 3'h7; // Select compare mask, 2K size
   localparam logic [2:0]  PIN_IDLE     = 3'h7; // Lines idle high after reset

   // ----------------------------------------------------------------
   // Self-timed write cycle
   // ----------------------------------------------------------------
   localparam int unsigned WR_TIME_US   = 5000; // Longest write cycle, in us
   localparam int unsigned CLK_MHZ      = 125;
   localparam int unsigned WR_CYCLES    = WR_TIME_US * CLK_MHZ;
   localparam int unsigned TIMER_W      = 20;

   // ----------------------------------------------------------------
   // Transfer phases
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE     = 5'h01,
      ST_DEVADDR  = 5'h02,
      ST_WORDADDR = 5'h04,
      ST_WRDATA   = 5'h08,
      ST_RDDATA   = 5'h10
   } eewr_state_t;

endpackage

/* File: inc/eewr_ev_if.sv */
// Line events passed from the pin conditioner to the protocol engine
`timescale 1ns/1ps
interface eewr_ev_if;
   logic start;      // Data fell while clock high
   logic stop;       // Data rose while clock high
   logic scl_rise;   // Serial clock rising edge
   logic scl_fall;   // Serial clock falling edge
   logic sda_lvl;    // Filtered data level
   logic wp_lvl;     // Filtered write-protect level

   modport src (output start, stop, scl_rise, scl_fall, sda_lvl, wp_lvl);
   modport dst (input  start, stop, scl_rise, scl_fall, sda_lvl, wp_lvl);
endinterface // eewr_ev_if

/* File: rtl/eewr_pin_sync.sv */
// Pin synchroniser and start/stop/edge detector for the two-wire lines
`timescale 1ns/1ps
module eewr_pin_sync (
   // Clock and reset
   input  wire logic sys_clk_in,
   input  wire logic resetn_in,
   // Raw pins
   input  wire logic scl_in,
   input  wire logic sda_in,
   input  wire logic wp_in,
   // Events
   eewr_ev_if.src    ev
);

   logic [2:0] raw;
   logic [2:0] s1_ff;
   logic [2:0] s2_ff;
   logic [2:0] s3_ff;
   logic [2:0] lvl_ff;
   logic [2:0] prev_ff;

   assign raw = {wp_in, sda_in, scl_in};

   // ----------------------------------------------------------------
   // Three-stage synchroniser, level taken when stages two and three agree
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         s1_ff <= eewr_pkg::PIN_IDLE;
         s2_ff <= eewr_pkg::PIN_IDLE;
         s3_ff <= eewr_pkg::PIN_IDLE;
      end else begin
         s1_ff <= raw;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // Agreement filter rejects a one-cycle glitch between stages
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         lvl_ff  <= eewr_pkg::PIN_IDLE;
         prev_ff <= eewr_pkg::PIN_IDLE;
      end else begin
         lvl_ff  <= (s2_ff & s3_ff) | (lvl_ff & (s2_ff ^ s3_ff));
         prev_ff <= lvl_ff;
      end
   end

   // Both lines carry the same lag, so start and stop keep their order
   assign ev.scl_rise = lvl_ff[0] & ~prev_ff[0];
   assign ev.scl_fall = ~lvl_ff[0] & prev_ff[0];
   assign ev.start    = ~lvl_ff[1] & prev_ff[1] & lvl_ff[0] & prev_ff[0];
   assign ev.stop     = lvl_ff[1] & ~prev_ff[1] & lvl_ff[0] & prev_ff[0];
   assign ev.sda_lvl  = lvl_ff[1];
   assign ev.wp_lvl   = lvl_ff[2];

   a_start_level: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      ev.start |-> ($past(lvl_ff[1]) && !lvl_ff[1] && lvl_ff[0]))
      else $error("start flagged without data falling under high clock");

endmodule // eewr_pin_sync

/* File: rtl/eewr_wr_timer.sv */
// Self-timed write cycle counter
`timescale 1ns/1ps
module eewr_wr_timer #(
   parameter int unsigned WR_CYCLES = eewr_pkg::WR_CYCLES
) (
   // Clock and reset
   input  wire logic sys_clk_in,
   input  wire logic resetn_in,
   // Control
   input  wire logic start_in,
   output logic      busy_out
);

   logic [eewr_pkg::TIMER_W-1:0] cnt_ff;
   logic [eewr_pkg::TIMER_W-1:0] span_ff;
   logic                         busy_ff;

   // ----------------------------------------------------------------
   // Down counter; busy holds for exactly WR_CYCLES cycles
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         cnt_ff  <= '0;
         busy_ff <= 1'b0;
      end else if (start_in && !busy_ff) begin
         cnt_ff  <= eewr_pkg::TIMER_W'(WR_CYCLES - 1);
         busy_ff <= 1'b1;
      end else if (busy_ff) begin
         cnt_ff  <= cnt_ff - 1'b1;
         busy_ff <= (cnt_ff != '0);
      end
   end

   assign busy_out = busy_ff;

   // Helper: length of the current busy stretch
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         span_ff <= '0;
      end else begin
         span_ff <= busy_ff ? span_ff + 1'b1 : '0;
      end
   end

   a_write_span: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      $fell(busy_ff) |-> (span_ff == eewr_pkg::TIMER_W'(WR_CYCLES)))
      else $error("write cycle length differs from configured count");

endmodule // eewr_wr_timer

/* File: rtl/eewr_slave.sv */
// Two-wire serial EEPROM target: addressing, page writes, reads, array
//
// How it works
// - Each start is followed by an 8-bit device word before any access.
// - Top four device-word bits must equal the device-type code.
// - Smallest size compares all three select bits with their pins.
// - Second size compares two select bits; third bit is a page bit.
// - Third size compares only the top select bit; two page bits follow.
// - Largest size compares none; page bits lead the word address.
// - Last device-word bit picks read (one) or write (zero).
// - Matching word is acknowledged low; otherwise stay silent and idle.
// - Byte write: word address then data, each acknowledged low.
// - After a write stop, run the timed cycle and ignore all inputs.
// - Page buffer holds 8 bytes on the smallest size, 16 otherwise.
// - Page write sends up to 7 or 15 more bytes, each acknowledged.
// - Writes increment only low in-page bits, wrapping within the page.
// - Polling start and device word is acknowledged only when write ends.
// - Address counter holds last accessed address plus one between transfers.
// - Read counter wraps from the array end to address zero.
// - Current read sends the byte at the counter; master nacks then stops.
// - Sequential read continues while the master acknowledges each byte.
// - Each transfer is eight bits plus a low acknowledge on clock nine.
// - Data falling under high clock is start; rising is stop.
// - Sample data on clock rise; change driven data after clock fall.
// - Write-protect high blocks all array writes.
`timescale 1ns/1ps
module eewr_slave #(
   parameter int unsigned VARIANT   = 3,      // 0:2K 1:4K 2:8K 3:16K
   parameter logic [3:0]  DEV_TYPE  = 4'h5,   // Device-type code, value arbitrary
   parameter int unsigned WR_CYCLES = eewr_pkg::WR_CYCLES
) (
   // Clock and reset
   input  wire logic sys_clk_in,
   input  wire logic resetn_in,
   // Two-wire bus
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_drv_out,
   output logic      sda_oe_out,
   // Straps and protection
   input  wire logic select_pin_high_in,
   input  wire logic select_pin_mid_in,
   input  wire logic select_pin_low_in,
   input  wire logic write_protect_in,
   // Status
   output logic      wr_busy_out
);

   // ----------------------------------------------------------------
   // Size-dependent geometry
   // ----------------------------------------------------------------
   localparam int unsigned DEPTH    = eewr_pkg::BASE_DEPTH << VARIANT;
   localparam int unsigned PG_BYTES = (VARIANT == 0) ? eewr_pkg::PAGE_SMALL
                                                     : eewr_pkg::PAGE_LARGE;
   localparam logic [eewr_pkg::ADDR_W-1:0] ADDR_MASK = eewr_pkg::ADDR_W'(DEPTH - 1);
   localparam logic [eewr_pkg::ADDR_W-1:0] PG_MASK   = eewr_pkg::ADDR_W'(PG_BYTES - 1);
   localparam logic [2:0] SEL_MASK = 3'(eewr_pkg::SEL_ALL << VARIANT);

   eewr_ev_if ev ();

   eewr_pkg::eewr_state_t          state_ff;
   logic [3:0]                     bit_cnt_ff;
   logic [7:0]                     shift_ff;
   logic [7:0]                     dev_ff;
   logic [eewr_pkg::ADDR_W-1:0]    addr_ff;
   logic                           sda_oe_ff;
   logic                           load_pend_ff;
   logic [7:0]                     pbuf_ff [eewr_pkg::PAGE_MAX];
   logic [eewr_pkg::PAGE_MAX-1:0]  pvalid_ff;
   logic [7:0]                     mem_ff [DEPTH];
   logic [2:0]                     sel_pins;
   logic                           wr_busy;
   logic                           rx_state;
   logic                           rx_byte_end;
   logic                           tx_load;
   logic                           commit;
   logic [eewr_pkg::ADDR_W-1:0]    page_base;
   logic [3:0]                     pg_idx;

   // ----------------------------------------------------------------
   // Pin conditioning and write timer
   // ----------------------------------------------------------------
   eewr_pin_sync u_pin_sync (
      .sys_clk_in (sys_clk_in),
      .resetn_in  (resetn_in),
      .scl_in     (scl_in),
      .sda_in     (sda_in),
      .wp_in      (write_protect_in),
      .ev         (ev.src)
   );

   eewr_wr_timer #(
      .WR_CYCLES  (WR_CYCLES)
   ) u_wr_timer (
      .sys_clk_in (sys_clk_in),
      .resetn_in  (resetn_in),
      .start_in   (commit),
      .busy_out   (wr_busy)
   );

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   // Type code plus only those select bits this size still compares
   function automatic logic dev_match(input logic [7:0] w);
      return (w[7:4] == DEV_TYPE) &&
             (((w[3:1] ^ sel_pins) & SEL_MASK) == 3'h0);
   endfunction

   // Page bits from the device word become the top of the word address
   function automatic logic [eewr_pkg::ADDR_W-1:0] full_addr(input logic [7:0] dev,
                                                            input logic [7:0] word);
      return {dev[3:1] & ~SEL_MASK, word} & ADDR_MASK;
   endfunction

   // In-page increment: upper bits hold, low bits roll over
   function automatic logic [eewr_pkg::ADDR_W-1:0] page_inc(
         input logic [eewr_pkg::ADDR_W-1:0] a);
      return (a & ~PG_MASK) | ((a + 1'b1) & PG_MASK);
   endfunction

   assign sel_pins    = {select_pin_high_in, select_pin_mid_in, select_pin_low_in};
   assign rx_state    = (state_ff == eewr_pkg::ST_DEVADDR) ||
                        (state_ff == eewr_pkg::ST_WORDADDR) ||
                        (state_ff == eewr_pkg::ST_WRDATA);
   // Full byte sits in the shifter on the fall that opens the ack clock
   assign rx_byte_end = rx_state && ev.scl_fall && (bit_cnt_ff == eewr_pkg::ACK_BIT);
   assign tx_load     = (state_ff == eewr_pkg::ST_RDDATA) && ev.scl_fall &&
                        (bit_cnt_ff == 4'h0) && load_pend_ff;
   assign page_base   = addr_ff & ~PG_MASK;
   assign pg_idx      = addr_ff[3:0] & PG_MASK[3:0];
   // Program only on a write stop with data, not while protected or busy
   assign commit      = ev.stop && (state_ff == eewr_pkg::ST_WRDATA) &&
                        (pvalid_ff != '0) && !ev.wp_lvl && !wr_busy;

   // ----------------------------------------------------------------
   // Bit counter and shifter
   // ----------------------------------------------------------------
   // Counter steps on clock rise and clears on start, so data is taken on the rise
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         bit_cnt_ff <= 4'h0;
         shift_ff   <= 8'h00;
      end else if (ev.start) begin
         bit_cnt_ff <= 4'h0;
      end else if (ev.scl_rise && state_ff != eewr_pkg::ST_IDLE) begin
         if (bit_cnt_ff == eewr_pkg::ACK_BIT) begin
            bit_cnt_ff <= 4'h0;
         end else begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (rx_state) begin
               shift_ff <= {shift_ff[6:0], ev.sda_lvl};
            end
         end
      end else if (tx_load) begin
         shift_ff <= mem_ff[addr_ff];
      end
   end

   // ----------------------------------------------------------------
   // Transfer phase
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         state_ff     <= eewr_pkg::ST_IDLE;
         dev_ff       <= 8'h00;
         load_pend_ff <= 1'b0;
      end else if (ev.start) begin
         // Inputs are ignored while programming; polling just sees no ack
         state_ff     <= wr_busy ? eewr_pkg::ST_IDLE : eewr_pkg::ST_DEVADDR;
         load_pend_ff <= 1'b0;
      end else if (ev.stop) begin
         state_ff     <= eewr_pkg::ST_IDLE;
         load_pend_ff <= 1'b0;
      end else if (rx_byte_end) begin
         unique case (state_ff)
            eewr_pkg::ST_DEVADDR: begin
               dev_ff <= shift_ff;
               if (dev_match(shift_ff)) begin
                  // Direction bit picks read or write
                  state_ff     <= shift_ff[0] ? eewr_pkg::ST_RDDATA
                                              : eewr_pkg::ST_WORDADDR;
                  load_pend_ff <= shift_ff[0];
               end else begin
                  state_ff <= eewr_pkg::ST_IDLE;
               end
            end
            eewr_pkg::ST_WORDADDR: state_ff <= eewr_pkg::ST_WRDATA;
            eewr_pkg::ST_WRDATA:   state_ff <= eewr_pkg::ST_WRDATA;
         endcase
      end else if (state_ff == eewr_pkg::ST_RDDATA) begin
         if (tx_load) begin
            load_pend_ff <= 1'b0;
         end else if (ev.scl_rise && bit_cnt_ff == eewr_pkg::ACK_BIT) begin
            // Master ack asks for another byte; a nack ends the read
            if (ev.sda_lvl) begin
               state_ff <= eewr_pkg::ST_IDLE;
            end else begin
               load_pend_ff <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Address counter
   // ----------------------------------------------------------------
   // Counter survives between transfers; reset only by the chip reset
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         addr_ff <= '0;
      end else if (rx_byte_end && state_ff == eewr_pkg::ST_WORDADDR) begin
         addr_ff <= full_addr(dev_ff, shift_ff);
      end else if (rx_byte_end && state_ff == eewr_pkg::ST_WRDATA) begin
         addr_ff <= page_inc(addr_ff);
      end else if (tx_load) begin
         addr_ff <= (addr_ff + 1'b1) & ADDR_MASK;
      end
   end

   // ----------------------------------------------------------------
   // Page buffer
   // ----------------------------------------------------------------
   // Bytes gather here so an overrun overwrites earlier ones in the page
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         pvalid_ff <= '0;
      end else if (rx_byte_end && state_ff == eewr_pkg::ST_WORDADDR) begin
         pvalid_ff <= '0;
      end else if (rx_byte_end && state_ff == eewr_pkg::ST_WRDATA) begin
         pbuf_ff[pg_idx]   <= shift_ff;
         pvalid_ff[pg_idx] <= 1'b1;
      end else if (ev.stop || ev.start) begin
         pvalid_ff <= pvalid_ff & {eewr_pkg::PAGE_MAX{!ev.stop}};
      end
   end

   // ----------------------------------------------------------------
   // Array
   // ----------------------------------------------------------------
   // Received bytes of the page land on the stop; the timer then models programming
   always_ff @(posedge sys_clk_in) begin
      for (int i = 0; i < PG_BYTES; i++) begin
         if (commit && pvalid_ff[i]) begin
            mem_ff[page_base | eewr_pkg::ADDR_W'(i)] <= pbuf_ff[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // Open-drain data driver
   // ----------------------------------------------------------------
   // Changes happen on clock fall, except the release on start or stop, which comes while the clock is high
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         sda_oe_ff <= 1'b0;
      end else if (ev.start || ev.stop) begin
         sda_oe_ff <= 1'b0;
      end else if (ev.scl_fall) begin
         if (rx_byte_end) begin
            // Ack low only for our device word, and always for later bytes
            sda_oe_ff <= (state_ff != eewr_pkg::ST_DEVADDR) ||
                         (dev_match(shift_ff) && !wr_busy);
         end else if (tx_load) begin
            sda_oe_ff <= ~mem_ff[addr_ff][7];
         end else if (state_ff == eewr_pkg::ST_RDDATA &&
                      bit_cnt_ff != 4'h0 && bit_cnt_ff != eewr_pkg::ACK_BIT) begin
            sda_oe_ff <= ~shift_ff[3'(7 - bit_cnt_ff)];
         end else begin
            sda_oe_ff <= 1'b0;                                   // Free line for master ack
         end
      end
   end

   assign sda_drv_out = 1'b0;
   assign sda_oe_out  = sda_oe_ff;
   assign wr_busy_out = wr_busy;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_start_to_addr: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (ev.start && !wr_busy) |=> (state_ff == eewr_pkg::ST_DEVADDR && bit_cnt_ff == 4'h0))
      else $error("start did not open a device word");

   a_nack_foreign: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (rx_byte_end && state_ff == eewr_pkg::ST_DEVADDR && !dev_match(shift_ff))
      |=> (!sda_oe_ff && state_ff == eewr_pkg::ST_IDLE))
      else $error("foreign device word was answered");

   a_ack_own: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (rx_byte_end && state_ff == eewr_pkg::ST_DEVADDR && dev_match(shift_ff) && !wr_busy)
      |=> sda_oe_ff)
      else $error("own device word not acknowledged");

   a_dir_select: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (rx_byte_end && state_ff == eewr_pkg::ST_DEVADDR && dev_match(shift_ff))
      |=> ((state_ff == eewr_pkg::ST_RDDATA) == $past(shift_ff[0])))
      else $error("direction bit ignored");

   a_busy_silent: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      wr_busy |-> !sda_oe_ff)
      else $error("line driven during write cycle");

   a_page_hold: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (rx_byte_end && state_ff == eewr_pkg::ST_WRDATA)
      |=> ((addr_ff & ~PG_MASK) == ($past(addr_ff) & ~PG_MASK)) &&
          ((addr_ff & PG_MASK) == (($past(addr_ff) + 1'b1) & PG_MASK)))
      else $error("write address left its page");

   a_read_wrap: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (tx_load && addr_ff == ADDR_MASK) |=> (addr_ff == '0))
      else $error("read counter did not wrap to zero");

   a_commit_busy: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      commit |=> wr_busy ##1 wr_busy)
      else $error("write stop did not start programming");

   a_wp_blocks: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (ev.stop && ev.wp_lvl && !wr_busy) |=> !wr_busy)
      else $error("array written while protected");

   a_rise_only: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (bit_cnt_ff != $past(bit_cnt_ff)) |-> ($past(ev.scl_rise) || $past(ev.start)))
      else $error("bit counter moved without clock rise");

endmodule // eewr_slave

/* File: verif/eewr_master.sv */
// Two-wire bus master model
`timescale 1ns/1ps
module eewr_master (
   // Link clock, wire level in; lines out, idle high
   input  wire logic link_clk_in,
   input  wire logic sda_in,
   output logic      scl_out = 1'b1,
   output logic      sda_out = 1'b1
);
   // A phase is four link cycles, long against the input filter
   // Two ns after the link edge lands on odd times, never on a system clock edge
   task automatic e(input logic c, input logic d);
      repeat (4) @(posedge link_clk_in);
      #2 {scl_out, sda_out} = {c, d};
   endtask
   // Clock/data pairs: 8'h78 start, 8'h2f stop plus settle
   task automatic cond(input logic [7:0] p);
      for (int i = 3; i >= 0; i--) e(p[2*i+1], p[2*i]);
   endtask
   task automatic start_cond();
      cond(8'h78);
   endtask
   task automatic stop_cond();
      cond(8'h2f);
   endtask
   // Nine bits MSB first, sampled late in clock high
   task automatic xfer(input logic [8:0] w, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         e(1'b0, w[i]);
         e(1'b1, w[i]);
         // Clock falls in its own step, after the line is read
         repeat (4) @(posedge link_clk_in);
         #2 r[i] = sda_in;
         scl_out = 1'b0;
      end
   endtask
endmodule // eewr_master

/* File: verif/eewr_slave_tb.sv */
// Self-checking bench for the EEPROM target
`timescale 1ns/1ps
module eewr_slave_tb;
   logic sys_clk_in = 1'b0, link_clk = 1'b0, resetn_in = 1'b0, wp = 1'b0, scl, m_sda, oe, drv, busy;
   logic [8:0] r;
   logic [2:0] sel = 3'h0; // Straps, random; ignored at the largest size
   logic [7:0] d, mem [0:2047];
   int n_errors = 0, n_checks = 0, seed = 32'h8af5;
   wire sda = m_sda & ~(oe & ~drv); // Pull-up wire
   // Clocks never share a rising edge; reset held 20 cycles
   always #4 sys_clk_in = ~sys_clk_in;
   always #15 link_clk = ~link_clk;
   initial #157 resetn_in = 1'b1;
   eewr_slave #(.DEV_TYPE(4'ha), .WR_CYCLES(1000)) u_eewr_slave (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
      .scl_in(scl), .sda_in(sda), .sda_drv_out(drv), .sda_oe_out(oe), .select_pin_high_in(sel[2]),
      .select_pin_mid_in(sel[1]), .select_pin_low_in(sel[0]), .write_protect_in(wp), .wr_busy_out(busy));
   eewr_master u_eewr_master (.link_clk_in(link_clk), .sda_in(sda), .scl_out(scl), .sda_out(m_sda));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      if (seen !== exp) n_errors++;
   endtask
   task automatic dev(input logic [7:0] w, input logic nak);
      u_eewr_master.start_cond();
      u_eewr_master.xfer({w, 1'b1}, r);
      chk({7'h0, r[0]}, {7'h0, nak});
   endtask
   task automatic seta(input logic [10:0] a);
      dev({4'ha, a[10:8], 1'b0}, 1'b0);
      u_eewr_master.xfer({a[7:0], 1'b1}, r);
      chk({7'h0, r[0]}, 8'h00);
   endtask
   // Where the k-th byte of a page write lands: low bits roll, page holds
   function automatic logic [10:0] pg_addr(input logic [10:0] a, input int k);
      return {a[10:4], 4'(a[3:0] + 4'(k))};
   endfunction
   // Page write; the image wraps inside the page
   task automatic wr(input logic [10:0] a, input int n, input logic p);
      wp = p;
      sel = 3'($random(seed));
      seta(a);
      for (int k = 0; k < n; k++) begin
         d = 8'($random(seed));
         if (!wp) mem[pg_addr(a, k)] = d;
         u_eewr_master.xfer({d, 1'b1}, r);
         chk({7'h0, r[0]}, 8'h00);
      end
      u_eewr_master.stop_cond();
      chk({7'h0, busy}, {7'h0, ~wp});
      dev(8'ha0, ~wp);
      u_eewr_master.stop_cond();
      for (int i = 0; i < 2000 && busy === 1'b1; i++) @(posedge sys_clk_in);
      // Step off the clock edge before the next pin change
      #2 $display("write test done at %h", a);
   endtask
   task automatic rd(input logic [10:0] a, input int n, input logic cur);
      if (!cur) seta(a);
      dev({4'ha, a[10:8], 1'b1}, 1'b0);
      for (int i = 0; i < n; i++) begin
         u_eewr_master.xfer({8'hff, i == n - 1}, r);
         chk(r[8:1], mem[11'(a + i)]);
      end
      u_eewr_master.stop_cond();
      $display("read test done at %h", a);
   endtask
   // Main sequence
   initial begin
      #400 dev(8'h35, 1'b1);
      $display("foreign word test done");
      wr(11'h3f5, 17, 1'b0);
      rd(11'h3f0, 15, 1'b0);
      rd(11'h3ff, 1, 1'b1);
      wr(11'h7fe, 2, 1'b0);
      wr(11'h000, 2, 1'b0);
      rd(11'h7fe, 4, 1'b0);
      wr(11'h3f0, 3, 1'b1);
      rd(11'h3f0, 3, 1'b0);
      $display("test sequence done");
      report_and_stop();
   end
   // Watchdog, about two and a half times the expected run
   initial #600000 begin
      n_errors++;
      report_and_stop();
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
endmodule // eewr_slave_tb
